// *** src/aopc_top.sv ***
// Purpose: Output launch, forwarded clock, power-down and calibration control.
// Assumes: sample_code is the true code of each sample on clk_sys, unclamped.
// Notes: Pins from outside pass aopc_sync; long delays are parameters.
module aopc_top
  import aopc_pkg::*;
#(
  parameter logic [POR_W-1:0] POR_SHORT = POR_DELAY_SHORT,
  parameter logic [POR_W-1:0] POR_LONG = POR_DELAY_LONG
) (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // Converter core result, same clock.
  input wire logic signed [RAW_W-1:0] sample_code,
  // Control pins.
  input wire logic power_down_pin,
  input wire logic cal_request_pin,
  input wire logic trim_delay_select,
  input wire logic output_edge_select,
  input wire logic output_swing_select,
  input wire logic input_coupling_select,
  input wire logic full_scale_select,
  // Output buses.
  output logic [CODE_W-1:0] primary_output_bus,
  output logic [CODE_W-1:0] delayed_output_bus,
  output logic out_of_range,
  output logic forwarded_output_clock_p,
  output logic forwarded_output_clock_n,
  output logic outputs_oe,
  // Status and analog controls.
  output logic trim_active,
  output logic afe_swing_high,
  output logic afe_dc_coupled,
  output logic afe_range_wide
);
  // ***************************************************************
  // Clamp function.
  // ***************************************************************
  function automatic logic [CODE_W:0] clamp_code(input logic signed [RAW_W-1:0] raw);
    logic [CODE_W:0] res;
    res = {1'b0, raw[CODE_W-1:0]};
    if (raw < CODE_MIN) begin
      res = {1'b1, 8'h00};
    end else if (raw > CODE_MAX) begin
      res = {1'b1, 8'hFF};
    end
    return res;
  endfunction

  // ***************************************************************
  // Pin synchronisation.
  // ***************************************************************
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic pd_s;
  logic cal_s;
  logic edge_s;

  assign pins_raw = {full_scale_select, input_coupling_select, output_swing_select,
                     output_edge_select, trim_delay_select, cal_request_pin, power_down_pin};
  assign pd_s = pins_s[PIN_PD];
  assign cal_s = pins_s[PIN_CAL];
  assign edge_s = pins_s[PIN_EDGE];

  aopc_sync #(.W(PIN_W)) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .pin_in(pins_raw),
    .pin_sync(pins_s)
  );

  // ***************************************************************
  // Power-down and calibration sequencing.
  // ***************************************************************
  aopc_state_e state_q;
  aopc_state_e state_d;
  logic pd_active_q;
  logic pd_active_d;
  logic [POR_W-1:0] por_cnt_q;
  logic [POR_W-1:0] por_limit;
  logic [11:0] cal_cnt_q;
  logic [3:0] low_cnt_q;
  logic [3:0] high_cnt_q;
  logic [1:0] boot_cnt_q;
  logic skip_por_q;
  logic cmd_start;

  assign por_limit = pins_s[PIN_DLY] ? POR_LONG : POR_SHORT;
  assign pd_active_d = pd_s && (state_d != ST_CAL);
  assign cmd_start = cal_s && !pd_s && state_q != ST_CAL && low_cnt_q == CAL_QUAL_CYCLES
                     && high_cnt_q == CAL_QUAL_CYCLES - 4'h1;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_WAIT_POR: begin
        if (cmd_start) begin
          state_d = ST_CAL;
        end else if (skip_por_q) begin
          state_d = ST_IDLE;
        end else if (!pd_s && por_cnt_q == por_limit) begin
          state_d = ST_CAL;
        end
      end
      ST_IDLE: begin
        if (cmd_start) begin
          state_d = ST_CAL;
        end
      end
      ST_CAL: begin
        if (cal_cnt_q == CAL_RUN_CYCLES - 12'h1) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_WAIT_POR;
      pd_active_q <= 1'b0;
      trim_active <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      pd_active_q <= pd_active_d;
      trim_active <= (state_d == ST_CAL);
    end
  end

  // Power-on delay counts only while power-down is low.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      por_cnt_q <= '0;
    end else if (clk_en && state_q == ST_WAIT_POR && !pd_s && por_cnt_q != por_limit) begin
      por_cnt_q <= por_cnt_q + 31'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cal_cnt_q <= '0;
    end else if (clk_en) begin
      cal_cnt_q <= (state_q == ST_CAL) ? cal_cnt_q + 12'h1 : 12'h0;
    end
  end

  // Request pin held high at power-up suppresses power-on calibration.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      boot_cnt_q <= '0;
      skip_por_q <= 1'b0;
    end else if (clk_en && boot_cnt_q != BOOT_CYCLES + 2'h1) begin
      boot_cnt_q <= boot_cnt_q + 2'h1;
      // The synchronised pin is only valid once both stages have filled.
      if (boot_cnt_q == BOOT_CYCLES) begin
        skip_por_q <= pins_s[PIN_CAL];
      end
    end
  end

  // Request qualifier: low run then high run, cleared while powered down.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      low_cnt_q <= '0;
      high_cnt_q <= '0;
    end else if (clk_en) begin
      if (pd_s || cmd_start) begin
        low_cnt_q <= '0;
        high_cnt_q <= '0;
      end else if (!cal_s) begin
        high_cnt_q <= '0;
        if (high_cnt_q != 4'h0) begin
          low_cnt_q <= 4'h1;
        end else if (low_cnt_q != CAL_QUAL_CYCLES) begin
          low_cnt_q <= low_cnt_q + 4'h1;
        end
      end else if (low_cnt_q != CAL_QUAL_CYCLES) begin
        low_cnt_q <= '0;
      end else if (high_cnt_q != CAL_QUAL_CYCLES) begin
        high_cnt_q <= high_cnt_q + 4'h1;
      end
    end
  end

  // ***************************************************************
  // Conversion pipeline and demultiplexed output launch.
  // ***************************************************************
  logic [CODE_W:0] stage_q [1:LAT_DELAYED];
  logic launch;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stage_q[1] <= '0;
    end else if (clk_en && !pd_active_d) begin
      stage_q[1] <= clamp_code(sample_code);
    end
  end

  // Stages hold in power-down, so they are stale until refilled.
  genvar gi;
  generate
    for (gi = 2; gi <= LAT_DELAYED; gi++) begin : g_pipe
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          stage_q[gi] <= '0;
        end else if (clk_en && !pd_active_d) begin
          stage_q[gi] <= stage_q[gi-1];
        end
      end
    end
  endgenerate

  // Data launches when the forwarded clock is about to take the selected level.
  assign launch = !pd_active_d && (forwarded_output_clock_p != edge_s);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      forwarded_output_clock_p <= 1'b0;
      forwarded_output_clock_n <= 1'b1;
      outputs_oe <= 1'b0;
    end else if (clk_en) begin
      outputs_oe <= !pd_active_d;
      if (!pd_active_d) begin
        forwarded_output_clock_p <= !forwarded_output_clock_p;
        forwarded_output_clock_n <= forwarded_output_clock_p;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      primary_output_bus <= '0;
      delayed_output_bus <= '0;
      out_of_range <= 1'b0;
    end else if (clk_en && launch) begin
      primary_output_bus <= stage_q[LAT_PRIMARY][CODE_W-1:0];
      delayed_output_bus <= stage_q[LAT_DELAYED][CODE_W-1:0];
      out_of_range <= stage_q[LAT_PRIMARY][CODE_W] | stage_q[LAT_DELAYED][CODE_W];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      afe_swing_high <= 1'b0;
      afe_dc_coupled <= 1'b0;
      afe_range_wide <= 1'b0;
    end else if (clk_en) begin
      afe_swing_high <= pins_s[PIN_SWING];
      afe_dc_coupled <= pins_s[PIN_COUP];
      afe_range_wide <= pins_s[PIN_FSR];
    end
  end

  // ***************************************************************
  // Assertions and covers.
  // ***************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  AST_EDGE_SELECT: assert property ($changed(primary_output_bus) |->
      forwarded_output_clock_p == $past(edge_s))
    else $error("Data changed on the wrong forwarded clock edge.");
  AST_FWD_CLOCK: assert property (clk_en && !pd_active_d |=>
      $changed(forwarded_output_clock_p) && forwarded_output_clock_n == !forwarded_output_clock_p)
    else $error("Forwarded clock pair did not toggle as a complement.");
  AST_RANGE_FLAG: assert property (clk_en && !pd_active_d ##1 (clk_en && !pd_active_d) |=>
      stage_q[2][CODE_W] == ($past(sample_code, 2) > CODE_MAX || $past(sample_code, 2) < CODE_MIN))
    else $error("Out-of-range marking does not match the sample.");
  AST_PD_HIZ: assert property (clk_en && pd_s && state_d != ST_CAL |=> !outputs_oe)
    else $error("Outputs still enabled in power-down.");
  AST_PD_WAITS_CAL: assert property (state_q == ST_CAL |-> !pd_active_q)
    else $error("Power-down entered during calibration.");
  AST_POR_FROZEN: assert property (state_q == ST_WAIT_POR && pd_s |=> $stable(por_cnt_q))
    else $error("Power-on delay counted during power-down.");
  AST_PD_NO_CAL: assert property (pd_active_q && state_q != ST_CAL |=> state_q != ST_CAL)
    else $error("Calibration started while powered down.");
  AST_POR_DELAY: assert property (state_q == ST_WAIT_POR && state_d == ST_CAL && !cmd_start |->
      por_cnt_q == por_limit)
    else $error("Power-on calibration started at the wrong count.");
  AST_TRIM_ACTIVE: assert property (trim_active == (state_q == ST_CAL))
    else $error("Calibration-active output disagrees with the sequencer.");
  AST_LATENCY: assert property (clk_en && launch |=>
      primary_output_bus == $past(stage_q[LAT_PRIMARY][CODE_W-1:0]) &&
      delayed_output_bus == $past(stage_q[LAT_DELAYED][CODE_W-1:0]))
    else $error("Output bus did not take the pipeline stage.");
  AST_CMD_QUAL: assert property (clk_en && state_q == ST_IDLE && state_d == ST_CAL |->
      low_cnt_q == CAL_QUAL_CYCLES && cal_s && $past(cal_s, 9) && !pd_s)
    else $error("Command calibration started without qualification.");

  COV_CMD_CAL: cover property (state_q == ST_IDLE ##1 state_q == ST_CAL);
  COV_POR_CAL: cover property (state_q == ST_WAIT_POR ##1 state_q == ST_CAL);
  COV_PD_ENTER: cover property (!pd_active_q ##1 pd_active_q);
  COV_RANGE: cover property ($rose(out_of_range));
endmodule // aopc_top

// *** src/aopc_pkg.sv ***
// Purpose: Shared constants for the converter output and power control block.
// Assumes: The sampling clock is clk_sys; one sample enters per enabled cycle.
// Notes: Long power-on delays are top-level parameters defaulting to these values.
package aopc_pkg;
  // ***************************************************************
  // Widths and pin synchroniser.
  // ***************************************************************
  localparam int CODE_W = 8;
  localparam int RAW_W = 10;
  localparam int SYNC_STAGES = 2;
  localparam int PIN_W = 7;
  // Positions of the static pins inside the synchronised pin vector.
  localparam int PIN_PD = 0;
  localparam int PIN_CAL = 1;
  localparam int PIN_DLY = 2;
  localparam int PIN_EDGE = 3;
  localparam int PIN_SWING = 4;
  localparam int PIN_COUP = 5;
  localparam int PIN_FSR = 6;
  // ***************************************************************
  // Pipeline latencies and code range.
  // ***************************************************************
  localparam int LAT_PRIMARY = 7;
  localparam int LAT_DELAYED = 8;
  localparam logic signed [RAW_W-1:0] CODE_MIN = 10'sh000;
  localparam logic signed [RAW_W-1:0] CODE_MAX = 10'sh0FF;
  // ***************************************************************
  // Calibration timing in sampling clock cycles.
  // ***************************************************************
  localparam int POR_W = 31;
  localparam logic [POR_W-1:0] POR_DELAY_SHORT = 31'h01000000;
  localparam logic [POR_W-1:0] POR_DELAY_LONG = 31'h40000000;
  localparam logic [3:0] CAL_QUAL_CYCLES = 4'hA;
  localparam logic [11:0] CAL_RUN_CYCLES = 12'h400;
  localparam logic [1:0] BOOT_CYCLES = 2'h2;
  // ***************************************************************
  // Calibration sequencer states.
  // ***************************************************************
  typedef enum logic [1:0] {ST_WAIT_POR, ST_IDLE, ST_CAL} aopc_state_e;
endpackage

// *** src/aopc_sync.sv ***
// Purpose: Two-flop synchroniser for static pins from outside the clock domain.
// Assumes: Each bit is an independent slow level.
// Notes: The first stage feeds only the second stage.
module aopc_sync
  import aopc_pkg::*;
#(
  parameter int W = 1
) (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // Level in and out.
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      pin_sync <= '0;
    end else if (clk_en) begin
      meta_q <= pin_in;
      pin_sync <= meta_q;
    end
  end
endmodule // aopc_sync

// *** verif/aopc_rx_model.sv ***
// Purpose: Capture logic that latches word pairs with the forwarded clock.
// Assumes: Outputs are only valid while outputs_oe is high.
// Notes: Captures on the forwarded clock edge opposite the launch edge.
module aopc_rx_model
  import aopc_pkg::*;
(
  // Forwarded link.
  input wire logic fwd_clk_p,
  input wire logic edge_sel,
  input wire logic oe,
  input wire logic [CODE_W-1:0] prim_bus,
  input wire logic [CODE_W-1:0] dly_bus,
  input wire logic oor,
  // Captured pair.
  output logic [CODE_W-1:0] cap_early,
  output logic [CODE_W-1:0] cap_late,
  output logic cap_oor,
  output int cap_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  int stale_cnt;
  initial begin
    cap_cnt = 0;
    stale_cnt = 5;
  end
  // Stale words after power-down are dropped before use.
  always @(negedge oe) begin
    stale_cnt = 5;
  end
  always @(fwd_clk_p) begin
    if (oe === 1'b1 && fwd_clk_p !== edge_sel) begin
      if (stale_cnt > 0) begin
        stale_cnt--;
      end else begin
        cap_early = dly_bus;
        cap_late = prim_bus;
        cap_oor = oor;
        cap_cnt++;
      end
    end
  end
endmodule // aopc_rx_model

// *** verif/aopc_top_bench.sv ***
// Purpose: Self-checking bench for the output and power control block.
// Assumes: Power-on limits are shortened to 100 and 300 cycles.
// Notes: Captured pairs are matched against the oldest queued samples.
module aopc_top_bench
  import aopc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, resetn, clk_en, power_down_pin, cal_request_pin, trim_delay_select;
  logic output_edge_select, output_swing_select, input_coupling_select, full_scale_select;
  logic signed [RAW_W-1:0] sample_code, nxt;
  logic [CODE_W-1:0] primary_output_bus, delayed_output_bus, prev_prim, cap_early, cap_late;
  logic out_of_range, fwd_p, fwd_n, outputs_oe, trim_active, cap_oor, stream_on, prev_clk;
  logic afe_swing_high, afe_dc_coupled, afe_range_wide;
  int cap_cnt, error_cnt, num_checks, seed, cyc, n, lim;
  logic signed [RAW_W-1:0] exp_q[$];

  aopc_top #(.POR_SHORT(31'h64), .POR_LONG(31'h12C)) DUT (.clk_sys(clk_sys), .resetn(resetn),
    .clk_en(clk_en), .sample_code(sample_code), .power_down_pin(power_down_pin),
    .cal_request_pin(cal_request_pin), .trim_delay_select(trim_delay_select),
    .output_edge_select(output_edge_select), .output_swing_select(output_swing_select),
    .input_coupling_select(input_coupling_select), .full_scale_select(full_scale_select),
    .primary_output_bus(primary_output_bus), .delayed_output_bus(delayed_output_bus),
    .out_of_range(out_of_range), .forwarded_output_clock_p(fwd_p),
    .forwarded_output_clock_n(fwd_n), .outputs_oe(outputs_oe), .trim_active(trim_active),
    .afe_swing_high(afe_swing_high), .afe_dc_coupled(afe_dc_coupled),
    .afe_range_wide(afe_range_wide));
  aopc_rx_model rx (.fwd_clk_p(fwd_p), .edge_sel(output_edge_select), .oe(outputs_oe),
    .prim_bus(primary_output_bus), .dly_bus(delayed_output_bus), .oor(out_of_range),
    .cap_early(cap_early), .cap_late(cap_late), .cap_oor(cap_oor), .cap_cnt(cap_cnt));
  // ***************************************************************
  // Helpers.
  // ***************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  function automatic logic [CODE_W-1:0] clip(input logic signed [RAW_W-1:0] v);
    if (v < 0) return 8'h00;
    if (v > 255) return 8'hFF;
    return v[CODE_W-1:0];
  endfunction
  task automatic cycles(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic wait_for(input logic use_oe, input logic val, input int max);
    n = 0;
    while ((use_oe ? outputs_oe : trim_active) !== val && n < max) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ***************************************************************
  // Clock, stimulus and watchers.
  // ***************************************************************
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 9000) begin
      error_cnt++;
      end_of_test();
    end
  end
  always @(negedge clk_sys) begin
    nxt = 10'($random(seed) % 320);
    sample_code <= nxt;
    exp_q.push_back(nxt);
  end
  always @(cap_cnt) begin
    while (exp_q.size() > 10) void'(exp_q.pop_front());
    if (exp_q.size() == 10) begin
      if (stream_on) begin
        check("delayed_word", cap_early, clip(exp_q[0]));
        check("primary_word", cap_late, clip(exp_q[1]));
        check("range_flag", cap_oor, clip(exp_q[0]) != exp_q[0] || clip(exp_q[1]) != exp_q[1]);
      end
      void'(exp_q.pop_front());
      void'(exp_q.pop_front());
    end
  end
  always @(posedge clk_sys) begin
    #1;
    check("clock_pair", fwd_n, !fwd_p);
    if (stream_on && outputs_oe === 1'b1 && primary_output_bus !== prev_prim)
      check("launch_edge", fwd_p, output_edge_select);
    prev_prim = primary_output_bus;
  end
  // ***************************************************************
  // Main sequence.
  // ***************************************************************
  initial begin
    seed = 24;
    {cyc, error_cnt, num_checks} = '0;
    {stream_on, resetn, cal_request_pin, trim_delay_select, prev_prim} = '0;
    {clk_en, power_down_pin, output_edge_select} = 3'h7;
    {output_swing_select, input_coupling_select, full_scale_select} = 3'h0;
    for (int sel = 0; sel < 2; sel++) begin
      @(negedge clk_sys);
      resetn = 0;
      power_down_pin = 1;
      trim_delay_select = sel[0];
      lim = sel ? 300 : 100;
      cycles(6);
      check("reset_oe", outputs_oe, 0);
      check("reset_clk_n", fwd_n, 1);
      resetn = 1;
      cycles(400);
      check("trim_in_pd", trim_active, 0);
      power_down_pin = 0;
      wait_for(0, 1, 1000);
      check("por_delay", n >= lim && n <= lim + 6, 1);
      wait_for(0, 0, 1100);
      check("trim_len", n, 1024);
    end
    {output_swing_select, input_coupling_select, full_scale_select} = 3'($random(seed));
    cycles(4);
    check("afe_swing", afe_swing_high, output_swing_select);
    check("afe_coup", afe_dc_coupled, input_coupling_select);
    check("afe_range", afe_range_wide, full_scale_select);
    stream_on = 1;
    cycles(100);
    stream_on = 0;
    output_edge_select = 0;
    cycles(12);
    stream_on = 1;
    cycles(100);
    stream_on = 0;
    prev_clk = fwd_p;
    clk_en = 0;
    cycles(10);
    check("en_clk_still", fwd_p, prev_clk);
    check("en_oe_still", outputs_oe, 1);
    clk_en = 1;
    power_down_pin = 1;
    wait_for(1, 0, 6);
    check("pd_oe", outputs_oe, 0);
    prev_clk = fwd_p;
    cal_request_pin = 0;
    cycles(15);
    cal_request_pin = 1;
    cycles(15);
    check("pd_cal_ignored", trim_active, 0);
    check("pd_clk_still", fwd_p, prev_clk);
    power_down_pin = 0;
    cycles(20);
    stream_on = 1;
    cycles(60);
    stream_on = 0;
    cal_request_pin = 0;
    cycles(5);
    cal_request_pin = 1;
    cycles(15);
    check("short_low", trim_active, 0);
    cal_request_pin = 0;
    cycles(12);
    cal_request_pin = 1;
    wait_for(0, 1, 30);
    check("cmd_start", n >= 10 && n <= 14, 1);
    cycles(100);
    power_down_pin = 1;
    cycles(20);
    check("oe_in_cal", outputs_oe, 1);
    wait_for(0, 0, 1100);
    wait_for(1, 0, 6);
    check("oe_after_cal", outputs_oe, 0);
    power_down_pin = 0;
    cycles(10);
    end_of_test();
  end
endmodule // aopc_top_bench
